// ### rtl/drive_profile.sv
`include "drive_profile_map.svh"

module drive_profile (
   // clock and reset
   input wire logic sys_clk_i,
   input wire logic rst_n_i,
   // command telegram
   input wire logic [15:0] cmd_word_i,
   input wire logic cmd_strobe_i,
   // drive feedback and configuration
   input wire drive_profile_pkg::drive_fbk_t fbk_i,
   input wire drive_profile_pkg::drive_cfg_t cfg_i,
   // actions and status
   output drive_profile_pkg::drive_action_t action_o,
   output logic [1:0] setup_o,
   output logic [15:0] state_word_o
);

   ////////////////////////////////////////////////////////////////////////
   // applied command word

   logic [15:0] cmd_q;
   logic [15:0] cmd_d;
   logic take_word;

   // a word with bit 10 low leaves the old command in force
   assign take_word = cmd_strobe_i && cmd_word_i[`CW_VALID]; // RULE9
   assign cmd_d = take_word ? cmd_word_i : cmd_q; // RULE9

   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         cmd_q <= `CMD_RST;
      end else begin
         cmd_q <= cmd_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // decoded command bits

   logic off1;
   logic off2;
   logic off3;
   logic all_on;
   logic no_coast;
   logic no_qstop;
   logic use_ramp;
   logic run_bit;
   logic jog_gate;

   assign off1 = !cmd_q[`CW_OFF1];
   assign off2 = !cmd_q[`CW_OFF2];
   assign off3 = !cmd_q[`CW_OFF3];
   assign all_on = !(off1 || off2 || off3);
   assign no_coast = cmd_q[`CW_COAST];
   assign no_qstop = cmd_q[`CW_QSTOP];
   assign use_ramp = cmd_q[`CW_HOLD];
   assign run_bit = cmd_q[`CW_RAMP];
   // jog is gated on quick-stop low with the four lowest bits high
   assign jog_gate = !no_qstop && all_on && no_coast; // RULE7 RULE8

   ////////////////////////////////////////////////////////////////////////
   // reset edge detection

   logic rst_bit_prev_q;
   logic reset_rise;

   // only the edge acts, a held bit would retrigger nothing
   assign reset_rise = cmd_q[`CW_RESET] && !rst_bit_prev_q; // RULE6

   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         rst_bit_prev_q <= 1'b0;
      end else begin
         rst_bit_prev_q <= cmd_q[`CW_RESET];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // fault state

   drive_profile_pkg::fault_state_t fault_q;
   drive_profile_pkg::fault_state_t fault_d;
   logic trip_q;

   // a new trip in the reset cycle wins, so no fault is lost
   always_comb begin
      fault_d = fault_q;
      case (fault_q)
         drive_profile_pkg::FAULT_CLEAR: begin
            if (fbk_i.tripped) begin
               fault_d = drive_profile_pkg::FAULT_TRIPPED;
            end
         end
         drive_profile_pkg::FAULT_TRIPPED: begin
            if (reset_rise && !fbk_i.tripped) begin // RULE17
               fault_d = drive_profile_pkg::FAULT_CLEAR;
            end
         end
         default: begin
            fault_d = drive_profile_pkg::FAULT_CLEAR;
         end
      endcase
   end

   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         fault_q <= drive_profile_pkg::FAULT_CLEAR;
      end else begin
         fault_q <= fault_d;
      end
   end

   assign trip_q = (fault_q == drive_profile_pkg::FAULT_TRIPPED);

   ////////////////////////////////////////////////////////////////////////
   // start-inhibit latch

   logic inhibit_q;
   logic inhibit_d;
   logic inhibit_set;
   logic inhibit_clr;

   // power-up sets it through the reset value
   assign inhibit_set = reset_rise || off2 || off3; // RULE19
   assign inhibit_clr = off1 && !off2 && !off3
      && cmd_q[`CW_VALID]; // RULE19
   assign inhibit_d = inhibit_set ? 1'b1 :
      (inhibit_clr ? 1'b0 : inhibit_q);

   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         inhibit_q <= 1'b1;
      end else begin
         inhibit_q <= inhibit_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // actions

   drive_profile_pkg::drive_action_t action_q;
   drive_profile_pkg::drive_action_t action_d;
   logic running;

   assign running = fbk_i.start_present || !fbk_i.out_freq_zero;

   always_comb begin
      action_d = '0;
      action_d.ramp_stop = off1 || !run_bit; // RULE23 RULE5
      action_d.coast = off2 || !no_coast; // RULE24 RULE2
      action_d.quick_stop = off3 || !no_qstop; // RULE1 RULE3
      action_d.hold_freq = !use_ramp; // RULE4
      // trip blocks start until a reset edge clears it
      action_d.start_ok = all_on && no_coast && no_qstop && run_bit
         && !trip_q; // RULE2 RULE3 RULE5 RULE17
      action_d.fault_reset = reset_rise; // RULE6
      action_d.jog1 = cmd_q[`CW_JOG1] && jog_gate; // RULE7
      action_d.jog2 = cmd_q[`CW_JOG2] && jog_gate; // RULE8
      action_d.ref_down = cmd_q[`CW_SLOW]; // RULE10 RULE11
      action_d.ref_up = cmd_q[`CW_CATCH]
         && !cmd_q[`CW_SLOW]; // RULE10 RULE11
      action_d.reverse = cmd_q[`CW_REV]
         && cfg_i.reverse_from_bus; // RULE14
      action_d.relay_on = cfg_i.relay_at_stop && fbk_i.out_freq_zero
         && !all_on; // RULE1 RULE24
   end

   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         action_q <= '0;
      end else begin
         action_q <= action_d;
      end
   end

   assign action_o = action_q;

   ////////////////////////////////////////////////////////////////////////
   // set-up selection

   setup_select u_setup (
      .sys_clk_i(sys_clk_i),
      .rst_n_i(rst_n_i),
      .req_i({cmd_q[`CW_SET_MSB], cmd_q[`CW_SET_LSB]}), // RULE12
      .multi_setup_i(cfg_i.multi_setup),
      .linked_i(cfg_i.setups_linked),
      .running_i(running),
      .setup_o(setup_o)
   );

   ////////////////////////////////////////////////////////////////////////
   // status word

   logic [15:0] state_q;
   logic [15:0] state_d;
   logic ready;

   assign ready = all_on && !trip_q; // RULE15 RULE16

   always_comb begin
      state_d = '0;
      state_d[`SW_CTRL_READY] = ready; // RULE15
      state_d[`SW_DRIVE_READY] = ready && fbk_i.power_ok;
      state_d[`SW_ENABLE] = ready; // RULE16
      state_d[`SW_TRIP] = trip_q; // RULE17
      state_d[`SW_ON2] = cmd_q[`CW_OFF2]; // RULE18
      state_d[`SW_ON3] = cmd_q[`CW_OFF3]; // RULE18
      state_d[`SW_INHIBIT] = inhibit_q; // RULE19
      state_d[`SW_WARNING] = fbk_i.warning;
      state_d[`SW_AT_REF] = fbk_i.speed_at_ref; // RULE20
      state_d[`SW_BUS_CTRL] = fbk_i.bus_control; // RULE21
      state_d[`SW_FREQ_OK] = fbk_i.freq_in_limit;
      state_d[`SW_RUNNING] = running; // RULE22
      state_d[`SW_OVERTEMP] = fbk_i.overtemp_stop;
      state_d[`SW_VOLT] = fbk_i.volt_exceeded;
      state_d[`SW_TORQUE] = fbk_i.torque_exceeded;
      state_d[`SW_TIMER] = fbk_i.timer_exceeded;
   end

   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         state_q <= `STATE_RST;
      end else begin
         state_q <= state_d;
      end
   end

   assign state_word_o = state_q;

   ////////////////////////////////////////////////////////////////////////
   // checks

   default clocking cb @(posedge sys_clk_i);
   endclocking
   default disable iff (!rst_n_i);

   chk_invalid_ignored: assert property ( // RULE9
      cmd_strobe_i && !cmd_word_i[`CW_VALID] |=> $stable(cmd_q))
      else $error("word with bit 10 low was applied");

   chk_valid_applied: assert property ( // RULE9
      take_word |=> cmd_q == $past(cmd_word_i))
      else $error("valid word not applied");

   chk_reset_edge: assert property ( // RULE6
      cmd_q[`CW_RESET] && !rst_bit_prev_q
      |=> action_q.fault_reset ##1 !action_q.fault_reset)
      else $error("reset pulse wrong on bit 07 edge");

   chk_reset_steady: assert property ( // RULE6
      !cmd_q[`CW_RESET] |=> !action_q.fault_reset)
      else $error("reset pulse without bit 07 edge");

   chk_jog_gated: assert property ( // RULE7
      action_q.jog1 || action_q.jog2
      |-> $past(!cmd_q[`CW_QSTOP] && (&cmd_q[3:0])))
      else $error("jog outside its gate");

   chk_trim_priority: assert property ( // RULE11
      cmd_q[`CW_SLOW] |=> action_q.ref_down && !action_q.ref_up)
      else $error("slow down did not win");

   chk_ready_low: assert property ( // RULE15
      (!all_on || trip_q) |=> !state_q[`SW_CTRL_READY]
      && !state_q[`SW_ENABLE])
      else $error("ready with off bit or trip");

   chk_enable_high: assert property ( // RULE16
      (all_on && !trip_q) |=> state_q[`SW_ENABLE])
      else $error("enable missing");

   chk_trip_held: assert property ( // RULE17
      trip_q && !reset_rise |=> trip_q ##1 state_q[`SW_TRIP])
      else $error("trip dropped without reset");

   chk_start_refused: assert property ( // RULE17
      trip_q |=> !action_q.start_ok)
      else $error("start allowed while tripped");

   chk_mirror_bits: assert property ( // RULE18
      1'b1 |=> state_q[`SW_ON3:`SW_ON2] == $past(cmd_q[2:1]))
      else $error("status 04/05 do not mirror");

   chk_inhibit_latch: assert property ( // RULE19
      (off2 || off3) |=> inhibit_q ##1 state_q[`SW_INHIBIT])
      else $error("inhibit not set by off2/off3");

   chk_reverse_gate: assert property ( // RULE14
      action_q.reverse |-> $past(cmd_q[`CW_REV] && cfg_i.reverse_from_bus))
      else $error("reverse without bus source");

   chk_run_status: assert property ( // RULE22
      !fbk_i.out_freq_zero |=> state_q[`SW_RUNNING])
      else $error("running status missing");

   chk_ramp_stop: assert property ( // RULE23 RULE5
      (off1 || !run_bit) |=> action_q.ramp_stop)
      else $error("ramp stop missing");

   chk_coast_stop: assert property ( // RULE24 RULE2
      (off2 || !no_coast) |=> action_q.coast)
      else $error("coast missing");

   chk_quick_stop: assert property ( // RULE1 RULE3
      (off3 || !no_qstop) |=> action_q.quick_stop)
      else $error("quick stop missing");

   chk_hold_freq: assert property ( // RULE4
      1'b1 |=> action_q.hold_freq == $past(!use_ramp))
      else $error("hold frequency does not follow bit 05");

   chk_start_gate: assert property ( // RULE5
      action_q.start_ok
      |-> $past(all_on && no_coast && no_qstop && run_bit))
      else $error("start allowed with a stop bit low");

   chk_relay_gate: assert property ( // RULE24
      action_q.relay_on
      |-> $past(cfg_i.relay_at_stop && fbk_i.out_freq_zero))
      else $error("relay driven off zero frequency");

   chk_trim_up: assert property ( // RULE10
      (cmd_q[`CW_CATCH] && !cmd_q[`CW_SLOW]) |=> action_q.ref_up)
      else $error("catch up missing");

   chk_speed_flag: assert property ( // RULE20
      1'b1 |=> state_q[`SW_AT_REF] == $past(fbk_i.speed_at_ref))
      else $error("status 08 does not follow speed");

   chk_bus_flag: assert property ( // RULE21
      1'b1 |=> state_q[`SW_BUS_CTRL] == $past(fbk_i.bus_control))
      else $error("status 09 does not follow bus control");

   chk_inhibit_clear: assert property ( // RULE19
      inhibit_clr && !inhibit_set |=> !inhibit_q)
      else $error("inhibit not cleared");

   cov_fault_reset: cover property (
      trip_q ##1 reset_rise ##1 !trip_q);

   cov_jog1: cover property (action_q.jog1);

   cov_ignored_word: cover property (
      cmd_strobe_i && !cmd_word_i[`CW_VALID]);

   cov_setup_change: cover property (!$stable(setup_o));

   cov_trip_entered: cover property (!trip_q ##1 trip_q);

endmodule : drive_profile

// ### rtl/drive_profile_map.svh
// How it works
// [RULE1] bit 02 low: quick stop, relay at 0 Hz
// [RULE2] bit 03 low coasts; high permits start
// [RULE3] bit 04 low: quick stop; high permits start
// [RULE4] bit 05 low freezes output frequency
// [RULE5] bit 06 low: ramp stop; high permits start
// [RULE6] reset only on rising edge of bit 07
// [RULE7] bit 08 jog 1 when 04=0, 00-03=1
// [RULE8] bit 09 jog 2 under the same gate
// [RULE9] whole word ignored while bit 10 low
// [RULE10] bit 11 lowers, bit 12 raises reference
// [RULE11] both trim bits set: decrease wins
// [RULE12] bits 13/14 pick one of four set-ups
// [RULE13] set-up switch needs multi-set-up, linking while running
// [RULE14] bit 15 reverses only with bus reverse source
// [RULE15] status 00 low on off bits or trip
// [RULE16] status 02 high only all on, no trip
// [RULE17] status 03 holds trip until reset; blocks start
// [RULE18] status 04/05 mirror command bits 01/02
// [RULE19] status 06 start-inhibit latch set and clear
// [RULE20] status 08 reports speed equals reference
// [RULE21] status 09 reports bus control accepted
// [RULE22] status 11 start present or frequency above zero
// [RULE23] bit 00 low: normal ramp stop
// [RULE24] bit 01 low coasts, relay at 0 Hz
// [RULE25] master sends full word, re-arms bit 07
`ifndef DRIVE_PROFILE_MAP_SVH
`define DRIVE_PROFILE_MAP_SVH

`define CW_OFF1 0
`define CW_OFF2 1
`define CW_OFF3 2
`define CW_COAST 3
`define CW_QSTOP 4
`define CW_HOLD 5
`define CW_RAMP 6
`define CW_RESET 7
`define CW_JOG1 8
`define CW_JOG2 9
`define CW_VALID 10
`define CW_SLOW 11
`define CW_CATCH 12
`define CW_SET_LSB 13
`define CW_SET_MSB 14
`define CW_REV 15

`define SW_CTRL_READY 0
`define SW_DRIVE_READY 1
`define SW_ENABLE 2
`define SW_TRIP 3
`define SW_ON2 4
`define SW_ON3 5
`define SW_INHIBIT 6
`define SW_WARNING 7
`define SW_AT_REF 8
`define SW_BUS_CTRL 9
`define SW_FREQ_OK 10
`define SW_RUNNING 11
`define SW_OVERTEMP 12
`define SW_VOLT 13
`define SW_TORQUE 14
`define SW_TIMER 15

`define CMD_RST 16'h0000
`define STATE_RST 16'h0040
`define SETUP_RST 2'h0

`endif

// ### rtl/drive_profile_pkg.sv
package drive_profile_pkg;

   typedef struct packed {
      logic ramp_stop;
      logic coast;
      logic quick_stop;
      logic hold_freq;
      logic start_ok;
      logic fault_reset;
      logic jog1;
      logic jog2;
      logic ref_down;
      logic ref_up;
      logic reverse;
      logic relay_on;
   } drive_action_t;

   typedef struct packed {
      logic tripped;
      logic power_ok;
      logic warning;
      logic speed_at_ref;
      logic bus_control;
      logic freq_in_limit;
      logic start_present;
      logic out_freq_zero;
      logic overtemp_stop;
      logic volt_exceeded;
      logic torque_exceeded;
      logic timer_exceeded;
   } drive_fbk_t;

   typedef struct packed {
      logic multi_setup;
      logic setups_linked;
      logic reverse_from_bus;
      logic relay_at_stop;
   } drive_cfg_t;

   typedef enum logic {
      FAULT_CLEAR,
      FAULT_TRIPPED
   } fault_state_t;

endpackage : drive_profile_pkg

// ### rtl/setup_select.sv
`include "drive_profile_map.svh"

module setup_select (
   // clock and reset
   input wire logic sys_clk_i,
   input wire logic rst_n_i,
   // request and conditions
   input wire logic [1:0] req_i,
   input wire logic multi_setup_i,
   input wire logic linked_i,
   input wire logic running_i,
   // active set-up, 0..3 for set-up 1..4
   output logic [1:0] setup_o
);

   logic [1:0] setup_q;
   logic [1:0] setup_d;
   logic allow;

   // a running motor may only hop between linked set-ups
   assign allow = multi_setup_i && (!running_i || linked_i); // RULE13
   assign setup_d = allow ? req_i : setup_q; // RULE12

   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         setup_q <= `SETUP_RST;
      end else begin
         setup_q <= setup_d;
      end
   end

   assign setup_o = setup_q;

   chk_setup_locked: assert property ( // RULE13
      @(posedge sys_clk_i) disable iff (!rst_n_i)
      (!multi_setup_i || (running_i && !linked_i)) |=> $stable(setup_q))
      else $error("set-up changed while not allowed");

   chk_setup_follows: assert property ( // RULE12
      @(posedge sys_clk_i) disable iff (!rst_n_i)
      (multi_setup_i && !running_i) |=> setup_q == $past(req_i))
      else $error("set-up did not follow request");

endmodule : setup_select

// ### bench/bus_master.sv
module bus_master (
   // clock
   input wire logic sys_clk_i,
   // telegram towards the drive
   output logic [15:0] cmd_word_o,
   output logic cmd_strobe_o
);
   timeunit 1ns;
   timeprecision 1ns;

   initial begin
      cmd_word_o = 16'h0000;
      cmd_strobe_o = 1'b0;
   end

   // word is inverted off the strobe so a stale copy of a word with bit 10 high has bit 10 low
   task automatic send(input logic [15:0] word);
      @(posedge sys_clk_i);
      #1;
      cmd_word_o = word;
      cmd_strobe_o = 1'b1;
      @(posedge sys_clk_i);
      #1;
      cmd_strobe_o = 1'b0;
      cmd_word_o = ~word;
   endtask : send
endmodule : bus_master

// ### bench/tb.sv
`define CHECK(nm, exp, got) begin \
   compares++; \
   if ((got) !== (exp)) begin \
      failures++; \
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got); \
   end \
end

module tb;
   timeunit 1ns;
   timeprecision 1ns;

   logic sys_clk = 1'b0;
   logic rst_n = 1'b0;
   wire logic [15:0] cmd_word;
   wire logic cmd_strobe;
   drive_profile_pkg::drive_fbk_t fbk;
   drive_profile_pkg::drive_cfg_t cfg;
   drive_profile_pkg::drive_action_t act;
   logic [1:0] setup;
   logic [15:0] st;
   int failures = 0;
   int compares = 0;
   int cycles = 0;

   always #50 sys_clk = ~sys_clk;

   bus_master master (
      .sys_clk_i(sys_clk),
      .cmd_word_o(cmd_word),
      .cmd_strobe_o(cmd_strobe)
   );

   drive_profile uut (
      .sys_clk_i(sys_clk),
      .rst_n_i(rst_n),
      .cmd_word_i(cmd_word),
      .cmd_strobe_i(cmd_strobe),
      .fbk_i(fbk),
      .cfg_i(cfg),
      .action_o(act),
      .setup_o(setup),
      .state_word_o(st)
   );

   task automatic give_verdict();
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : give_verdict

   // whole run needs about 140 cycles
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 3000) begin
         failures++;
         give_verdict();
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // answer lands two edges after the taking edge
   task automatic wait_answer();
      repeat (2) @(posedge sys_clk);
      #1;
   endtask : wait_answer

   task automatic apply(input logic [15:0] w);
      master.send(w);
      wait_answer();
   endtask : apply

   ////////////////////////////////////////////////////////////////////////
   task automatic t_start();
      apply(16'h047e);
      `CHECK("inhibit", 1'b0, st[6])
      `CHECK("ramp_stop", 1'b1, act.ramp_stop)
      apply(16'h047f);
      `CHECK("start_ok", 1'b1, act.start_ok)
      `CHECK("state", 16'h0035, st & 16'h0075)
   endtask : t_start

   task automatic t_stop_bits();
      logic off;
      for (int b = 0; b < 7; b++) begin
         apply(16'h047f & ~(16'h0001 << b));
         off = (b < 3);
         if (b == 0 || b == 6) `CHECK("ramp", 1'b1, act.ramp_stop)
         if (b == 1 || b == 3) `CHECK("coast", 1'b1, act.coast)
         if (b == 2 || b == 4) `CHECK("qstop", 1'b1, act.quick_stop)
         if (b == 5) `CHECK("hold", 1'b1, act.hold_freq)
         if (b == 1 || b == 2) `CHECK("inhibit", 1'b1, st[6])
         `CHECK("relay", off, act.relay_on)
         `CHECK("ready", !off, st[0])
         `CHECK("enable", !off, st[2])
         `CHECK("on2", b != 1, st[4])
         `CHECK("on3", b != 2, st[5])
      end
   endtask : t_stop_bits

   task automatic t_invalid();
      apply(16'h047f);
      apply(16'h0000);
      `CHECK("coast", 1'b0, act.coast)
      `CHECK("on2", 1'b1, st[4])
   endtask : t_invalid

   task automatic t_jog();
      apply(16'h076f);
      `CHECK("jog1", 1'b1, act.jog1)
      `CHECK("jog2", 1'b1, act.jog2)
      apply(16'h077f);
      `CHECK("jog1", 1'b0, act.jog1)
      `CHECK("jog2", 1'b0, act.jog2)
   endtask : t_jog

   task automatic t_trim();
      logic [15:0] tw [3] = '{16'h0c7f, 16'h147f, 16'h1c7f};
      for (int i = 0; i < 3; i++) begin
         apply(tw[i]);
         `CHECK("down", tw[i][11], act.ref_down)
         `CHECK("up", tw[i][12] & ~tw[i][11], act.ref_up)
      end
   endtask : t_trim

   task automatic t_reverse();
      cfg.reverse_from_bus = 1'b1;
      apply(16'h847f);
      `CHECK("reverse", 1'b1, act.reverse)
      apply(16'h047f);
      `CHECK("reverse", 1'b0, act.reverse)
      cfg.reverse_from_bus = 1'b0;
      apply(16'h847f);
      `CHECK("reverse", 1'b0, act.reverse)
   endtask : t_reverse

   task automatic t_setup();
      cfg.multi_setup = 1'b1;
      for (int k = 0; k < 4; k++) begin
         apply(16'h047f | (16'(k) << 13));
         `CHECK("setup", 2'(k), setup)
      end
      cfg.multi_setup = 1'b0;
      apply(16'h047f);
      `CHECK("setup", 2'h3, setup)
      // running and unlinked: switch must be refused
      cfg.multi_setup = 1'b1;
      fbk.start_present = 1'b1;
      apply(16'h047f);
      `CHECK("setup", 2'h3, setup)
      `CHECK("running", 1'b1, st[11])
      cfg.setups_linked = 1'b1;
      apply(16'h047f);
      `CHECK("setup", 2'h0, setup)
      fbk.start_present = 1'b0;
      cfg.setups_linked = 1'b0;
      wait_answer();
      `CHECK("running", 1'b0, st[11])
   endtask : t_setup

   task automatic t_feedback();
      fbk.speed_at_ref = 1'b1;
      fbk.bus_control = 1'b1;
      wait_answer();
      `CHECK("at_ref", 1'b1, st[8])
      `CHECK("bus_ctrl", 1'b1, st[9])
      fbk.speed_at_ref = 1'b0;
      fbk.bus_control = 1'b0;
      wait_answer();
      `CHECK("at_ref", 1'b0, st[8])
      `CHECK("bus_ctrl", 1'b0, st[9])
      // turning motor: running without a start bit, relay stays off
      fbk.out_freq_zero = 1'b0;
      apply(16'h047e);
      `CHECK("running", 1'b1, st[11])
      `CHECK("relay", 1'b0, act.relay_on)
      fbk.out_freq_zero = 1'b1;
      cfg.relay_at_stop = 1'b0;
      wait_answer();
      `CHECK("relay", 1'b0, act.relay_on)
      cfg.relay_at_stop = 1'b1;
      wait_answer();
      `CHECK("relay", 1'b1, act.relay_on)
   endtask : t_feedback

   task automatic t_trip();
      apply(16'h047f);
      @(posedge sys_clk);
      #1;
      fbk.tripped = 1'b1;
      @(posedge sys_clk);
      #1;
      fbk.tripped = 1'b0;
      repeat (4) @(posedge sys_clk);
      #1;
      `CHECK("trip", 1'b1, st[3])
      `CHECK("start_ok", 1'b0, act.start_ok)
      `CHECK("ready", 1'b0, st[0])
      // the reset pulse stands one cycle, from one edge after the taking edge
      master.send(16'h04ff);
      @(posedge sys_clk);
      #1;
      `CHECK("freset", 1'b1, act.fault_reset)
      @(posedge sys_clk);
      #1;
      `CHECK("freset", 1'b0, act.fault_reset)
      `CHECK("trip", 1'b0, st[3])
      `CHECK("inhibit", 1'b1, st[6])
      `CHECK("start_ok", 1'b1, act.start_ok)
      // bit held high: no second edge, no second reset
      apply(16'h04ff);
      `CHECK("freset", 1'b0, act.fault_reset)
   endtask : t_trip

   ////////////////////////////////////////////////////////////////////////
   initial begin
      fbk = '0;
      fbk.out_freq_zero = 1'b1;
      cfg = '0;
      cfg.relay_at_stop = 1'b1;
      repeat (4) @(posedge sys_clk);
      #1;
      rst_n = 1'b1;
      `CHECK("state_rst", 16'h0040, st)
      `CHECK("setup_rst", 2'h0, setup)
      t_start();
      t_stop_bits();
      t_invalid();
      t_jog();
      t_trim();
      t_reverse();
      t_setup();
      t_feedback();
      t_trip();
      give_verdict();
   end
endmodule : tb
